// ---- fewg_pkg.sv ----
`default_nettype none

package fewg_pkg;

  // register offsets, byte addresses on the plain register port
  localparam logic [7:0] FEWG_OFF_CTRL = 8'h00;
  localparam logic [7:0] FEWG_OFF_ALARM_FLAGS = 8'h04;
  localparam logic [7:0] FEWG_OFF_ALARM_FLAG_CLEAR = 8'h08;
  localparam logic [7:0] FEWG_OFF_UNLOCK_SEQUENCE = 8'h0C;
  localparam logic [7:0] FEWG_OFF_SECTOR_PERMIT_LOW = 8'h10;
  localparam logic [7:0] FEWG_OFF_SECTOR_PERMIT_HIGH = 8'h14;

  // field positions
  localparam int FEWG_BIT_PC_FLAG = 0;
  localparam int FEWG_BIT_LOCK_FLAG = 1;
  localparam int FEWG_BIT_IE_PC = 3;
  localparam int FEWG_BIT_IE_LOCK = 4;
  localparam int FEWG_UNLOCK_MSB = 15;

  // reset values
  localparam logic [31:0] FEWG_RST_PERMIT = 32'h0000_0000;
  localparam logic [1:0] FEWG_RST_FLAGS = 2'h0;
  localparam logic [1:0] FEWG_RST_IE = 2'h0;

  // unlock key pair, in order
  localparam logic [15:0] FEWG_KEY_FIRST = 16'h5A5A;
  localparam logic [15:0] FEWG_KEY_SECOND = 16'hA5A5;

  // geometry
  localparam int FEWG_SECTORS = 128;
  localparam int FEWG_SECTOR_W = 7;
  localparam int FEWG_PERMIT_BITS = 64;

  // operation kinds from the program/erase sequencer
  typedef enum logic [1:0]
  {
    FEWG_OP_READ = 2'b00,
    FEWG_OP_PROGRAM = 2'b01,
    FEWG_OP_SECTOR_ERASE = 2'b10,
    FEWG_OP_CHIP_ERASE = 2'b11
  } fewg_op_e;

  // unlock sequencer states
  typedef enum logic [1:0]
  {
    FEWG_UL_LOCKED = 2'b00,
    FEWG_UL_HALF = 2'b01,
    FEWG_UL_OPEN = 2'b10
  } fewg_unlock_e;

endpackage : fewg_pkg

`default_nettype wire

// ---- fewg_chk_if.sv ----
`timescale 1ns/100ps
`default_nettype none

interface fewg_chk_if;
  logic [1:0] op_kind;
  logic [6:0] target_sector;
  logic [6:0] pc_sector;
  logic pc_in_flash;
  logic [63:0] permit;
  logic deny_lock;
  logic deny_pc;

  modport asker_mp (
    output op_kind,
    output target_sector,
    output pc_sector,
    output pc_in_flash,
    output permit,
    input deny_lock,
    input deny_pc
  );

  modport judge_mp (
    input op_kind,
    input target_sector,
    input pc_sector,
    input pc_in_flash,
    input permit,
    output deny_lock,
    output deny_pc
  );
endinterface : fewg_chk_if

`default_nettype wire

// ---- fewg_check.sv ----
`timescale 1ns/100ps
`default_nettype none

module fewg_check (
  fewg_chk_if.judge_mp chk
);
  logic is_modify;
  logic is_chip;
  logic [5:0] pair_idx;
  logic pair_permit;
  logic all_permit;

  assign is_chip = (chk.op_kind == fewg_pkg::FEWG_OP_CHIP_ERASE);
  assign is_modify = (chk.op_kind != fewg_pkg::FEWG_OP_READ);
  // two sectors share one bit: drop the low sector bit
  assign pair_idx = chk.target_sector[6:1];
  assign pair_permit = chk.permit[pair_idx];
  assign all_permit = &chk.permit;

  // whole-array erase needs every pair open, a sector op only its own pair
  assign chk.deny_lock = is_modify & (is_chip ? ~all_permit : ~pair_permit);
  // whole-array erase always covers the running sector
  assign chk.deny_pc = is_modify & chk.pc_in_flash
    & (is_chip | (chk.pc_sector == chk.target_sector));
endmodule : fewg_check

`default_nettype wire

// ---- fewg_unlock.sv ----
`timescale 1ns/100ps
`default_nettype none

module fewg_unlock (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // write events
  input wire logic key_wr_in,
  input wire logic [15:0] key_in,
  input wire logic other_wr_in,
  // state
  output logic open_out
);
  fewg_pkg::fewg_unlock_e state_r;
  fewg_pkg::fewg_unlock_e state_nxt;

  always_comb
  begin
    state_nxt = state_r;
    if (key_wr_in)
    begin
      // a first key always restarts, so a stray write cannot wedge the pair
      if (state_r == fewg_pkg::FEWG_UL_HALF && key_in == fewg_pkg::FEWG_KEY_SECOND)
        state_nxt = fewg_pkg::FEWG_UL_OPEN;
      else if (key_in == fewg_pkg::FEWG_KEY_FIRST)
        state_nxt = fewg_pkg::FEWG_UL_HALF;
      else
        state_nxt = fewg_pkg::FEWG_UL_LOCKED;
    end
    else if (other_wr_in)
    begin
      // any other write breaks a half pair or uses up the open slot
      unique case (state_r)
        fewg_pkg::FEWG_UL_LOCKED: state_nxt = fewg_pkg::FEWG_UL_LOCKED;
        fewg_pkg::FEWG_UL_HALF: state_nxt = fewg_pkg::FEWG_UL_LOCKED;
        fewg_pkg::FEWG_UL_OPEN: state_nxt = fewg_pkg::FEWG_UL_LOCKED;
        default: state_nxt = fewg_pkg::FEWG_UL_LOCKED;
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
      state_r <= fewg_pkg::FEWG_UL_LOCKED;
    else
      state_r <= state_nxt;
  end

  assign open_out = (state_r == fewg_pkg::FEWG_UL_OPEN);
endmodule : fewg_unlock

`default_nettype wire

// ---- fewg_top.sv ----
// Operation
// - bit 1 flags locked-sector rejection
// - bit 0 flags running-sector rejection
// - write 0 to clear bit 1 clears it
// - write 0 to clear bit 0 clears it
// - keys 5A5A then A5A5 open writes
// - one write per unlock, then relock
// - reserved upper bits read zero
// - low permit bit n covers sectors 2n, 2n+1
// - high permit bit n covers 64+2n, 65+2n
// - permit bit 0 forbids, 1 allows
// - permit registers reset to all zeros
// - locked target suppressed, alarm and interrupt
// - running-sector target suppressed, alarm and interrupt
// - two enables gate the two alarm interrupts
// - whole-array erase needs every permit set
//
// Design decision made here: strobed register access.
`timescale 1ns/100ps
`default_nettype none

module fewg_top #(
  parameter int SECTOR_W = fewg_pkg::FEWG_SECTOR_W
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // sequencer request
  input wire logic op_req_in,
  input wire logic [1:0] op_kind_in,
  input wire logic [SECTOR_W-1:0] op_sector_in,
  input wire logic [SECTOR_W-1:0] pc_sector_in,
  input wire logic pc_in_flash_in,
  // sequencer answer
  output logic op_grant_out,
  output logic op_abort_out,
  // interrupt
  output logic irq_out
);

  // address decode
  logic hit_ctrl;
  logic hit_flags;
  logic hit_clear;
  logic hit_unlock;
  logic hit_permit_lo;
  logic hit_permit_hi;
  logic hit_guarded;

  assign hit_ctrl = (reg_addr_in == fewg_pkg::FEWG_OFF_CTRL);
  assign hit_flags = (reg_addr_in == fewg_pkg::FEWG_OFF_ALARM_FLAGS);
  assign hit_clear = (reg_addr_in == fewg_pkg::FEWG_OFF_ALARM_FLAG_CLEAR);
  assign hit_unlock = (reg_addr_in == fewg_pkg::FEWG_OFF_UNLOCK_SEQUENCE);
  assign hit_permit_lo = (reg_addr_in == fewg_pkg::FEWG_OFF_SECTOR_PERMIT_LOW);
  assign hit_permit_hi = (reg_addr_in == fewg_pkg::FEWG_OFF_SECTOR_PERMIT_HIGH);
  assign hit_guarded = hit_ctrl | hit_clear | hit_permit_lo | hit_permit_hi;

  // unlock sequencer
  logic unlock_open;
  logic key_wr;
  logic other_wr;
  logic write_ok;

  assign key_wr = reg_wr_in & hit_unlock;
  // every write that is not a key write counts, mapped or not, so a
  // stray store between the keys or after them always closes the door
  assign other_wr = reg_wr_in & ~hit_unlock;
  assign write_ok = reg_wr_in & hit_guarded & unlock_open;

  fewg_unlock u_unlock (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .key_wr_in(key_wr),
    .key_in(reg_wdata_in[fewg_pkg::FEWG_UNLOCK_MSB:0]),
    .other_wr_in(other_wr),
    .open_out(unlock_open)
  );

  // control: interrupt enables
  logic [1:0] irq_enable_r;

  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
      irq_enable_r <= fewg_pkg::FEWG_RST_IE;
    else if (write_ok && hit_ctrl)
      irq_enable_r <= reg_wdata_in[fewg_pkg::FEWG_BIT_IE_LOCK:fewg_pkg::FEWG_BIT_IE_PC];
  end

  // sector permission registers
  logic [31:0] permit_bits_low_r;
  logic [31:0] permit_bits_high_r;

  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
      permit_bits_low_r <= fewg_pkg::FEWG_RST_PERMIT;
    else if (write_ok && hit_permit_lo)
      permit_bits_low_r <= reg_wdata_in;
  end

  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
      permit_bits_high_r <= fewg_pkg::FEWG_RST_PERMIT;
    else if (write_ok && hit_permit_hi)
      permit_bits_high_r <= reg_wdata_in;
  end

  // permission check
  fewg_chk_if chk ();

  assign chk.op_kind = op_kind_in;
  assign chk.target_sector = op_sector_in;
  assign chk.pc_sector = pc_sector_in;
  assign chk.pc_in_flash = pc_in_flash_in;
  assign chk.permit = {permit_bits_high_r, permit_bits_low_r};

  fewg_check u_check (
    .chk(chk.judge_mp)
  );

  // sequencer answer, one cycle after the request
  logic deny_any;

  assign deny_any = chk.deny_lock | chk.deny_pc;

  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      op_grant_out <= 1'h0;
      op_abort_out <= 1'h0;
    end
    else
    begin
      op_grant_out <= op_req_in & ~deny_any;
      op_abort_out <= op_req_in & deny_any;
    end
  end

  // alarm flags: hardware set wins over a clear in the same cycle
  logic lock_violation_flag_r;
  logic pc_sector_violation_flag_r;
  logic set_lock;
  logic set_pc;
  logic clr_lock;
  logic clr_pc;

  assign set_lock = op_req_in & chk.deny_lock;
  assign set_pc = op_req_in & chk.deny_pc;
  // a zero clears, a one leaves the flag alone
  assign clr_lock = write_ok & hit_clear & ~reg_wdata_in[fewg_pkg::FEWG_BIT_LOCK_FLAG];
  assign clr_pc = write_ok & hit_clear & ~reg_wdata_in[fewg_pkg::FEWG_BIT_PC_FLAG];

  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
      lock_violation_flag_r <= fewg_pkg::FEWG_RST_FLAGS[fewg_pkg::FEWG_BIT_LOCK_FLAG];
    else if (set_lock)
      lock_violation_flag_r <= 1'h1;
    else if (clr_lock)
      lock_violation_flag_r <= 1'h0;
  end

  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
      pc_sector_violation_flag_r <= fewg_pkg::FEWG_RST_FLAGS[fewg_pkg::FEWG_BIT_PC_FLAG];
    else if (set_pc)
      pc_sector_violation_flag_r <= 1'h1;
    else if (clr_pc)
      pc_sector_violation_flag_r <= 1'h0;
  end

  // interrupt, level while any enabled flag stands
  logic [1:0] flags_now;

  assign flags_now = {lock_violation_flag_r, pc_sector_violation_flag_r};

  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
      irq_out <= 1'h0;
    else
      irq_out <= |(flags_now & irq_enable_r);
  end

  // read mux; write-only and unmapped words read zero
  logic [31:0] rd_word;

  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (hit_ctrl)
      rd_word[fewg_pkg::FEWG_BIT_IE_LOCK:fewg_pkg::FEWG_BIT_IE_PC] = irq_enable_r;
    else if (hit_flags)
      rd_word[fewg_pkg::FEWG_BIT_LOCK_FLAG:fewg_pkg::FEWG_BIT_PC_FLAG] = flags_now;
    else if (hit_permit_lo)
      rd_word = permit_bits_low_r;
    else if (hit_permit_hi)
      rd_word = permit_bits_high_r;
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
      reg_rdata_out <= 32'h0000_0000;
    else if (reg_rd_in)
      reg_rdata_out <= rd_word;
    else
      reg_rdata_out <= 32'h0000_0000;
  end

endmodule : fewg_top

`default_nettype wire

// ---- fewg_seq_model.sv ----
`timescale 1ns/100ps
`default_nettype none

module fewg_seq_model (
  // clock
  input wire logic clk_in,
  // command from the bench
  input wire logic go_in,
  input wire logic [1:0] kind_in,
  input wire logic [6:0] sec_in,
  // request to the guard
  output logic op_req_out,
  output logic [1:0] op_kind_out,
  output logic [6:0] op_sector_out
);
  // idle lines flip so a stale target can never pass as a live one
  always_ff @(posedge clk_in)
  begin
    op_req_out <= go_in;
    op_kind_out <= go_in ? kind_in : ~op_kind_out;
    op_sector_out <= go_in ? sec_in : ~op_sector_out;
  end
endmodule : fewg_seq_model

`default_nettype wire

// ---- fewg_top_chk.sv ----
`timescale 1ns/100ps
`default_nettype none

module fewg_top_chk #(
  parameter int SECTOR_W = 7
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  // sequencer and interrupt
  input wire logic op_req_in,
  input wire logic [1:0] op_kind_in,
  input wire logic [SECTOR_W-1:0] op_sector_in,
  input wire logic [SECTOR_W-1:0] pc_sector_in,
  input wire logic pc_in_flash_in,
  input wire logic op_grant_out,
  input wire logic op_abort_out,
  input wire logic irq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  property p_one; op_req_in |-> ##1 (op_grant_out ^ op_abort_out);
  endproperty
  a_one: assert property (p_one) else $error("not one answer");
  property p_read; op_req_in && op_kind_in == 2'h0 |=> op_grant_out;
  endproperty
  a_read: assert property (p_read) else $error("read refused");
  property p_pc; op_req_in && op_kind_in != 2'h0 && pc_in_flash_in
    && pc_sector_in == op_sector_in |=> op_abort_out;
  endproperty
  a_pc: assert property (p_pc) else $error("running sector hit");
  property p_chip; op_req_in && op_kind_in == 2'h3 && pc_in_flash_in |=> op_abort_out;
  endproperty
  a_chip: assert property (p_chip) else $error("chip erase passed");
  property p_rise; $rose(irq_out) |-> $past(op_abort_out) || $past(reg_wr_in, 2);
  endproperty
  a_rise: assert property (p_rise) else $error("irq without cause");
  property p_fall; $fell(irq_out) |-> $past(reg_wr_in, 2);
  endproperty
  a_fall: assert property (p_fall) else $error("irq dropped");
  property p_rsv; reg_rd_in && reg_addr_in == 8'h04 |=> reg_rdata_out[31:2] == 30'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("flag bits high");
  property p_wo; reg_rd_in && reg_addr_in inside {8'h08, 8'h0C} |=> reg_rdata_out == 32'h0;
  endproperty
  a_wo: assert property (p_wo) else $error("write only read");
  c_abort: cover property (op_req_in ##1 op_abort_out);
  c_grant: cover property (op_req_in && op_kind_in != 2'h0 ##1 op_grant_out);
  c_irq: cover property ($rose(irq_out));
endmodule : fewg_top_chk

bind fewg_top fewg_top_chk #(.SECTOR_W(SECTOR_W)) fewg_top_chk_inst (
  .clk_in, .reset_n_in, .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
  .op_req_in, .op_kind_in, .op_sector_in, .pc_sector_in, .pc_in_flash_in,
  .op_grant_out, .op_abort_out, .irq_out
);

`default_nettype wire

// ---- fewg_top_tb.sv ----
`timescale 1ns/100ps
`default_nettype none

module fewg_top_tb;
  logic clk_in, op_req_in, op_grant_out, op_abort_out, irq_out;
  logic reset_n_in = 1'h0;
  logic reg_wr_in = 1'h0;
  logic reg_rd_in = 1'h0;
  logic go = 1'h0;
  logic pc_in_flash_in = 1'h0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0;
  logic [31:0] reg_rdata_out;
  logic [1:0] kd = 2'h0;
  logic [1:0] op_kind_in;
  logic [6:0] sc = 7'h00;
  logic [6:0] pc_sector_in = 7'h00;
  logic [6:0] op_sector_in;
  int miscompares = 0;
  int checked = 0;
  // rows: kind, sector, running from flash on that sector, abort expected
  logic [1:0] rk[11] = '{2'h1, 2'h2, 2'h1, 2'h2, 2'h1, 2'h1, 2'h2, 2'h1, 2'h0, 2'h1, 2'h3};
  logic [6:0] rs[11] = '{7'h04, 7'h05, 7'h06, 7'h3F, 7'h3D, 7'h40, 7'h7F, 7'h42, 7'h06,
    7'h04, 7'h00};
  logic rf[11] = '{1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0};
  logic re[11] = '{1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1};

  fewg_top fewg_top_inst (
    .clk_in, .reset_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .op_req_in, .op_kind_in, .op_sector_in, .pc_sector_in,
    .pc_in_flash_in, .op_grant_out, .op_abort_out, .irq_out
  );
  fewg_seq_model fewg_seq_model_inst (
    .clk_in, .go_in(go), .kind_in(kd), .sec_in(sc), .op_req_out(op_req_in),
    .op_kind_out(op_kind_in), .op_sector_out(op_sector_in)
  );

  task automatic wrap_up;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      miscompares++;
      $display("FAIL %0t seen %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'h1;
    @(posedge clk_in);
    reg_wr_in <= 1'h0;
  endtask : wr
  // read data stand for one cycle only
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'h1;
    @(posedge clk_in);
    reg_rd_in <= 1'h0;
    #1 chk(reg_rdata_out, e);
  endtask : rc
  task automatic gw(input logic [7:0] a, input logic [31:0] d);
    wr(8'h0C, 32'h5A5A);
    wr(8'h0C, 32'hA5A5);
    wr(a, d);
  endtask : gw
  task automatic op(input logic [1:0] k, input logic [6:0] s, input logic f, input logic e);
    @(posedge clk_in);
    go <= 1'h1;
    kd <= k;
    sc <= s;
    pc_sector_in <= s;
    pc_in_flash_in <= f;
    @(posedge clk_in);
    go <= 1'h0;
    @(posedge clk_in);
    #1 chk(32'({op_abort_out, op_grant_out}), 32'({e, !e}));
  endtask : op

  initial
  begin
    clk_in = 1'h0;
    forever #2.5 clk_in = ~clk_in;
  end
  initial
  begin
    #50000;
    miscompares++;
    wrap_up();
  end
  initial
  begin
    repeat (6) @(posedge clk_in);
    reset_n_in <= 1'h1;
    rc(8'h10, 32'h0);
    rc(8'h14, 32'h0);
    op(2'h1, 7'h05, 1'h0, 1'h1);
    rc(8'h04, 32'h2);
    chk(32'(irq_out), 32'h0);
    gw(8'h00, 32'h10);
    repeat (2) @(posedge clk_in);
    #1 chk(32'(irq_out), 32'h1);
    rc(8'h00, 32'h10);
    gw(8'h08, 32'h3);
    rc(8'h04, 32'h2);
    gw(8'h08, 32'h1);
    rc(8'h04, 32'h0);
    chk(32'(irq_out), 32'h0);
    // a key out of order or a stray write must leave writes shut
    gw(8'h10, 32'h8000_0004);
    wr(8'h14, 32'h1);
    wr(8'h0C, 32'hA5A5);
    wr(8'h0C, 32'h5A5A);
    wr(8'h14, 32'h1);
    wr(8'h0C, 32'h5A5A);
    wr(8'h40, 32'h0);
    wr(8'h0C, 32'hA5A5);
    wr(8'h14, 32'h1);
    rc(8'h14, 32'h0);
    // only the low half of a key write is compared
    wr(8'h0C, 32'hFFFF_5A5A);
    wr(8'h0C, 32'h1234_A5A5);
    wr(8'h14, 32'h2);
    rc(8'h14, 32'h2);
    gw(8'h14, 32'h8000_0001);
    rc(8'h10, 32'h8000_0004);
    rc(8'h14, 32'h8000_0001);
    for (int i = 0; i < 11; i++)
      op(rk[i], rs[i], rf[i], re[i]);
    rc(8'h04, 32'h3);
    gw(8'h00, 32'h8);
    gw(8'h08, 32'h1);
    rc(8'h04, 32'h1);
    chk(32'(irq_out), 32'h1);
    gw(8'h08, 32'h2);
    rc(8'h04, 32'h0);
    chk(32'(irq_out), 32'h0);
    gw(8'h10, 32'hFFFF_FFFF);
    gw(8'h14, 32'hFFFF_FFFF);
    op(2'h3, 7'h00, 1'h0, 1'h0);
    op(2'h3, 7'h00, 1'h1, 1'h1);
    rc(8'h08, 32'h0);
    rc(8'h0C, 32'h0);
    rc(8'h40, 32'h0);
    @(posedge clk_in);
    reset_n_in <= 1'h0;
    repeat (6) @(posedge clk_in);
    reset_n_in <= 1'h1;
    rc(8'h10, 32'h0);
    rc(8'h14, 32'h0);
    rc(8'h04, 32'h0);
    rc(8'h00, 32'h0);
    chk(32'(irq_out), 32'h0);
    wrap_up();
  end
endmodule : fewg_top_tb

`default_nettype wire
